// ---- rwic_top.sv ----
// reset sequencing, wake-up and interrupt vectoring with axi4-lite registers
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module rwic_top #(
    parameter int POWERUP_CYCLES = rwic_pkg::POWERUP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [rwic_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rwic_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic master_clear_pin,
    input wire logic por_trip,
    input wire logic osc_input_pin,
    input wire logic osc_amp_ok,
    // core side
    input wire logic watchdog_timeout,
    input wire logic sleep_instr,
    input wire logic watchdog_clear_instr,
    input wire logic return_from_irq_instr,
    input wire logic core_irq_slot,
    input wire logic [15:0] core_pc,
    input wire logic ext_irq_event,
    input wire logic timer0_overflow_event,
    input wire logic counter_pin_irq_event,
    input wire logic periph_irq_flag,
    output logic core_reset,
    output logic core_stall,
    output logic pc_load,
    output logic [15:0] pc_load_value,
    output logic stack_push,
    output logic [15:0] stack_push_addr,
    output logic stack_pop
);
    import rwic_pkg::*;

    typedef enum logic [2:0] {
        ST_POR_WAIT = 3'h0,
        ST_CLEAR_HOLD = 3'h1,
        ST_TIMEOUT = 3'h2,
        ST_RUN = 3'h3,
        ST_SLEEP = 3'h4,
        ST_WATCHDOG_PULSE = 3'h5
    } rwic_state_t;

    typedef enum logic [1:0] {
        KIND_POR = 2'h0,
        KIND_RUN = 2'h1,
        KIND_SLEEP = 2'h2,
        KIND_WAKE = 2'h3
    } rwic_kind_t;

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [3:0] pins_sync;
    logic clear_hi;
    logic por_ok;
    logic osc_lvl;
    logic amp_ok;
    logic clear_prev;
    logic osc_prev;
    logic clear_rise;
    logic osc_pulse;

    rwic_sync2 #(
        .W(4)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({master_clear_pin, por_trip, osc_input_pin, osc_amp_ok}),
        .sync_out(pins_sync)
    );

    assign clear_hi = pins_sync[3];
    assign por_ok = pins_sync[2];
    assign osc_lvl = pins_sync[1];
    assign amp_ok = pins_sync[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clear_prev <= 1'h0;
            osc_prev <= 1'h0;
        end else begin
            clear_prev <= clear_hi;
            osc_prev <= osc_lvl;
        end
    end

    assign clear_rise = clear_hi && !clear_prev;
    assign osc_pulse = osc_lvl && !osc_prev && amp_ok;

    // ------------------------------------------------------------
    // registers and interrupt request
    // ------------------------------------------------------------
    rwic_state_t state;
    rwic_state_t next_state;
    rwic_kind_t kind;
    rwic_kind_t next_kind;
    rwic_osc_mode_t osc_mode;
    rwic_irq_status_t irq;
    logic global_irq_disable;
    logic watchdog_expired_flag;
    logic powerdown_flag;
    logic [POWERUP_W-1:0] powerup_cnt;
    logic [OSC_STARTUP_W-1:0] osc_startup_cnt;
    logic need_osc_startup;
    logic powerup_done;
    logic osc_startup_done;
    logic [3:0] pending;
    logic wake_irq;
    logic take;
    logic [15:0] vec;
    logic [1:0] sel;
    logic next_reset;
    logic release_core;
    logic sw_wr;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;

    assign pending[0] = irq.ext_pin_irq_flag && irq.ext_pin_irq_enable;
    assign pending[1] = irq.timer0_overflow_flag && irq.timer0_irq_enable;
    assign pending[2] = irq.counter_pin_irq_flag && irq.counter_pin_irq_enable;
    assign pending[3] = irq.periph_irq_flag && irq.periph_irq_enable;
    assign wake_irq = |pending;
    assign take = (state == ST_RUN) && (next_state == ST_RUN) && core_irq_slot
        && !global_irq_disable && wake_irq;

    always_comb begin
        vec = VEC_PERIPH;
        sel = 2'h3;
        if (pending[0]) begin
            vec = VEC_EXT_PIN;
            sel = 2'h0;
        end else if (pending[1]) begin
            vec = VEC_TIMER0;
            sel = 2'h1;
        end else if (pending[2]) begin
            vec = VEC_COUNTER_PIN;
            sel = 2'h2;
        end
    end

    // ------------------------------------------------------------
    // time-out counters
    // ------------------------------------------------------------
    assign need_osc_startup = (osc_mode == MODE_CRYSTAL
        || osc_mode == MODE_LOW_FREQ_CRYSTAL) && (kind != KIND_RUN);
    assign powerup_done = (kind != KIND_POR)
        || (powerup_cnt == POWERUP_W'(POWERUP_CYCLES));
    assign osc_startup_done = !need_osc_startup
        || (osc_startup_cnt == OSC_STARTUP_W'(OSC_STARTUP_PULSES));

    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_TIMEOUT || !clear_hi) begin
            powerup_cnt <= '0;
            osc_startup_cnt <= '0;
        end else begin
            if (!powerup_done) begin
                powerup_cnt <= powerup_cnt + POWERUP_W'(1);
            end
            if (!osc_startup_done && osc_pulse) begin
                osc_startup_cnt <= osc_startup_cnt + OSC_STARTUP_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_kind = kind;
        unique case (state)
            ST_POR_WAIT: begin
                if (por_ok) begin
                    next_state = clear_hi ? ST_TIMEOUT : ST_CLEAR_HOLD;
                end
            end
            ST_CLEAR_HOLD: begin
                if (clear_rise) begin
                    next_state = (kind == KIND_RUN) ? ST_RUN : ST_TIMEOUT;
                end
            end
            ST_TIMEOUT: begin
                if (!clear_hi) begin
                    next_state = ST_CLEAR_HOLD;
                    if (kind == KIND_WAKE) begin
                        next_kind = KIND_SLEEP;
                    end
                end else if (powerup_done && osc_startup_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!clear_hi) begin
                    next_state = ST_CLEAR_HOLD;
                    next_kind = KIND_RUN;
                end else if (watchdog_timeout) begin
                    next_state = ST_WATCHDOG_PULSE;
                    next_kind = KIND_RUN;
                end else if (sleep_instr) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!clear_hi) begin
                    next_state = ST_CLEAR_HOLD;
                    next_kind = KIND_SLEEP;
                end else if (watchdog_timeout) begin
                    next_state = ST_TIMEOUT;
                    next_kind = KIND_SLEEP;
                end else if (wake_irq) begin
                    next_state = ST_TIMEOUT;
                    next_kind = KIND_WAKE;
                end
            end
            ST_WATCHDOG_PULSE: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_POR_WAIT;
                next_kind = KIND_POR;
            end
        endcase
    end

    assign next_reset = (next_state == ST_POR_WAIT)
        || (next_state == ST_CLEAR_HOLD) || (next_state == ST_WATCHDOG_PULSE)
        || (next_state == ST_TIMEOUT && next_kind != KIND_WAKE);
    assign release_core = (next_state == ST_RUN) && (state != ST_RUN)
        && (kind != KIND_WAKE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_POR_WAIT;
            kind <= KIND_POR;
        end else begin
            state <= next_state;
            kind <= next_kind;
        end
    end

    // status flags per reset and wake cause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_expired_flag <= 1'h1;
            powerdown_flag <= 1'h1;
        end else if (state == ST_RUN) begin
            if (!clear_hi || watchdog_clear_instr) begin
                watchdog_expired_flag <= 1'h1;
                powerdown_flag <= 1'h1;
            end else if (watchdog_timeout) begin
                watchdog_expired_flag <= 1'h0;
                powerdown_flag <= 1'h1;
            end else if (sleep_instr) begin
                watchdog_expired_flag <= 1'h1;
                powerdown_flag <= 1'h0;
            end
        end else if (state == ST_SLEEP) begin
            if (!clear_hi || !watchdog_timeout) begin
                if (!clear_hi || wake_irq) begin
                    watchdog_expired_flag <= 1'h1;
                    powerdown_flag <= 1'h0;
                end
            end else begin
                watchdog_expired_flag <= 1'h0;
                powerdown_flag <= 1'h0;
            end
        end
    end

    // core control outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_reset <= 1'h1;
            core_stall <= 1'h1;
            pc_load <= 1'h0;
            pc_load_value <= RESET_VECTOR;
            stack_push <= 1'h0;
            stack_push_addr <= 16'h0000;
            stack_pop <= 1'h0;
        end else begin
            core_reset <= next_reset;
            core_stall <= next_state != ST_RUN;
            pc_load <= release_core || take;
            pc_load_value <= take ? vec : RESET_VECTOR;
            stack_push <= take;
            if (take) begin
                stack_push_addr <= core_pc;
            end
            stack_pop <= return_from_irq_instr && state == ST_RUN;
        end
    end

    // ------------------------------------------------------------
    // global disable and interrupt flags
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || next_reset) begin
            global_irq_disable <= 1'h1;
        end else if (take) begin
            global_irq_disable <= 1'h1;
        end else if (sw_wr && wr_addr == CPU_STATUS_OFS) begin
            global_irq_disable <= wr_data[GID_BIT];
        end else if (return_from_irq_instr && state == ST_RUN) begin
            global_irq_disable <= 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= IRQ_STATUS_RST;
        end else begin
            irq.periph_irq_flag <= periph_irq_flag;
            if (sw_wr && wr_addr == IRQ_STATUS_OFS) begin
                irq.periph_irq_enable <= wr_data[3];
                irq.counter_pin_irq_enable <= wr_data[2];
                irq.timer0_irq_enable <= wr_data[1];
                irq.ext_pin_irq_enable <= wr_data[0];
                irq.counter_pin_irq_flag <= wr_data[6] || counter_pin_irq_event;
                irq.timer0_overflow_flag <= wr_data[5] || timer0_overflow_event;
                irq.ext_pin_irq_flag <= wr_data[4] || ext_irq_event;
            end else begin
                irq.ext_pin_irq_flag <= ext_irq_event
                    || (irq.ext_pin_irq_flag && !(take && sel == 2'h0));
                irq.timer0_overflow_flag <= timer0_overflow_event
                    || (irq.timer0_overflow_flag && !(take && sel == 2'h1));
                irq.counter_pin_irq_flag <= counter_pin_irq_event
                    || (irq.counter_pin_irq_flag && !(take && sel == 2'h2));
            end
        end
    end

    // oscillator configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_mode <= OSC_MODE_RST;
        end else if (sw_wr && wr_addr == OSC_CFG_OFS) begin
            osc_mode <= rwic_osc_mode_t'(wr_data[1:0]);
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic aw_have;
    logic w_have;
    logic [3:0] wr_strb;

    assign sw_wr = aw_have && w_have && !s_axi_bvalid && wr_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'h0;
            w_have <= 1'h0;
            wr_addr <= '0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            s_axi_awready <= 1'h0;
            s_axi_wready <= 1'h0;
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'h1;
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'h0;
            end else if (!aw_have && !s_axi_bvalid) begin
                s_axi_awready <= 1'h1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'h1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'h0;
            end else if (!w_have && !s_axi_bvalid) begin
                s_axi_wready <= 1'h1;
            end
            if (aw_have && w_have && !s_axi_bvalid) begin
                aw_have <= 1'h0;
                w_have <= 1'h0;
                s_axi_bvalid <= 1'h1;
                s_axi_bresp <= (wr_addr == CPU_STATUS_OFS
                    || wr_addr == IRQ_STATUS_OFS || wr_addr == OSC_CFG_OFS)
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'h1;
        unique case (s_axi_araddr)
            CPU_STATUS_OFS: begin
                rd_word[GID_BIT] = global_irq_disable;
                rd_word[WDE_BIT] = watchdog_expired_flag;
                rd_word[PDF_BIT] = powerdown_flag;
            end
            IRQ_STATUS_OFS: rd_word[7:0] = irq;
            OSC_CFG_OFS: rd_word[1:0] = osc_mode;
            default: rd_hit = 1'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'h0;
                s_axi_rvalid <= 1'h1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'h0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'h1;
            end
        end
    end

endmodule

// ---- rwic_pkg.sv ----
// constants, types and operation list for the reset, wake and interrupt control
//
// Operation
// - start-up counter holds reset 1024 oscillator cycles after power-on or wake; interrupt wake holds only core_stall, with core_reset low
// - start-up delay only in crystal modes, only on power-on or wake
// - start-up counter counts oscillator pulses once amplitude threshold is reached
// - at power-on trip with master clear high both timers start together
// - power-up waits 96 ms and 1024 cycles; wake 1024 crystal; master clear none (code still runs the 1024-pulse start-up on master clear from sleep)
// - time-out counting restarts from the latest rising edge of master clear
// - expired and powerdown flags follow the documented reset and wake cases
// - every reset loads the program counter with the reset vector 0000h
// - interrupt wake continues at next instruction, vectoring afterwards if enabled
// - global disable at status bit 4 blocks all interrupts when set
// - every reset sets the global interrupt disable bit
// - each source gated by its enable; peripherals also by peripheral enable
// - accepting an interrupt sets disable, pushes return address, loads vector
// - return from interrupt pops the stack and clears global disable together
// - vectors 0008h pin, 0010h timer 0, 0018h counter pin, 0020h peripherals
// - simultaneous interrupts vector by fixed priority, external pin highest
// - flags set on their event regardless of enables or global disable
// - peripheral flag is not cleared on vectoring; it requests until cleared
package rwic_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int POWERUP_TIME_MS = 96;
    localparam int POWERUP_CYCLES = POWERUP_TIME_MS * (CLK_HZ / 1000);
    localparam int POWERUP_W = 23;
    localparam int OSC_STARTUP_PULSES = 1024;
    localparam int OSC_STARTUP_W = 11;

    // ------------------------------------------------------------
    // vectors
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VEC_EXT_PIN = 16'h0008;
    localparam logic [15:0] VEC_TIMER0 = 16'h0010;
    localparam logic [15:0] VEC_COUNTER_PIN = 16'h0018;
    localparam logic [15:0] VEC_PERIPH = 16'h0020;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] CPU_STATUS_OFS = 4'h0;
    localparam logic [3:0] IRQ_STATUS_OFS = 4'h4;
    localparam logic [3:0] OSC_CFG_OFS = 4'h8;
    localparam int GID_BIT = 4;
    localparam int WDE_BIT = 3;
    localparam int PDF_BIT = 2;
    localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_CRYSTAL = 2'h0,
        MODE_LOW_FREQ_CRYSTAL = 2'h1,
        MODE_EXT_CLOCK = 2'h2,
        MODE_RES_CAP = 2'h3
    } rwic_osc_mode_t;

    localparam rwic_osc_mode_t OSC_MODE_RST = MODE_CRYSTAL;

    typedef struct packed {
        logic periph_irq_flag;
        logic counter_pin_irq_flag;
        logic timer0_overflow_flag;
        logic ext_pin_irq_flag;
        logic periph_irq_enable;
        logic counter_pin_irq_enable;
        logic timer0_irq_enable;
        logic ext_pin_irq_enable;
    } rwic_irq_status_t;

endpackage

// ---- rwic_sync2.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module rwic_sync2 #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ---- rwic_properties.sv ----
// concurrent checks on the core-side outputs
`timescale 1ns/100ps
module rwic_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_reset,
    input wire logic core_stall,
    input wire logic core_irq_slot,
    input wire logic return_from_irq_instr,
    input wire logic [15:0] core_pc,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value,
    input wire logic stack_push,
    input wire logic [15:0] stack_push_addr,
    input wire logic stack_pop
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst_pc;
        $fell(core_reset) |-> ##[0:3] pc_load && pc_load_value == 16'h0000;
    endproperty
    property p_vec;
        pc_load && stack_push |-> pc_load_value inside
            {16'h0008, 16'h0010, 16'h0018, 16'h0020};
    endproperty
    property p_push_load;
        stack_push |-> pc_load;
    endproperty
    property p_slot;
        stack_push |-> $past(core_irq_slot);
    endproperty
    property p_addr;
        stack_push |-> stack_push_addr == $past(core_pc);
    endproperty
    property p_pop;
        return_from_irq_instr && !core_stall |=> stack_pop;
    endproperty
    property p_pop_cause;
        stack_pop |-> $past(return_from_irq_instr);
    endproperty
    property p_quiet;
        core_reset |-> !stack_push && !stack_pop;
    endproperty
    a_rst_pc: assert property (p_rst_pc)
        else $error("reset vector not loaded");
    a_vec: assert property (p_vec)
        else $error("bad vector");
    a_push_load: assert property (p_push_load)
        else $error("push without load");
    a_slot: assert property (p_slot)
        else $error("push without slot");
    a_addr: assert property (p_addr)
        else $error("wrong return address");
    a_pop: assert property (p_pop)
        else $error("no pop");
    a_pop_cause: assert property (p_pop_cause)
        else $error("stray pop");
    a_quiet: assert property (p_quiet)
        else $error("stack move in reset");
    c_push: cover property (stack_push);
    c_pop: cover property (stack_pop);
    c_rel: cover property ($fell(core_reset));
endmodule
bind rwic_top rwic_properties u_prop (.*);

// ---- rwic_osc_model.sv ----
// oscillator: free pulses, amplitude good after a few
`timescale 1ns/100ps
module rwic_osc_model (
    output logic osc_input_pin,
    output logic osc_amp_ok
);
    int n;
    initial begin
        osc_input_pin = 1'b0;
        osc_amp_ok = 1'b0;
        n = 0;
        forever begin
            #43;
            osc_input_pin = ~osc_input_pin;
            n = n + 1;
            if (n == 32)
                osc_amp_ok = 1'b1;
        end
    end
endmodule

// ---- test_reset_wake_interrupt_control.sv ----
// self-checking bench for the reset, wake and interrupt control
`timescale 1ns/100ps
module test_reset_wake_interrupt_control;
    import rwic_pkg::*;
    logic aclk, aresetn, master_clear_pin, por_trip, periph_irq_flag;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, osc_input_pin, osc_amp_ok;
    logic core_reset, core_stall, pc_load, stack_push, stack_pop;
    logic [15:0] core_pc, pc_load_value, stack_push_addr, lv;
    logic [7:0] ev;
    logic watchdog_timeout, sleep_instr, watchdog_clear_instr;
    logic return_from_irq_instr, core_irq_slot, ext_irq_event;
    logic timer0_overflow_event, counter_pin_irq_event;
    int err_total, num_checks, cyc, npl;
    assign {watchdog_clear_instr, watchdog_timeout, sleep_instr,
        counter_pin_irq_event, timer0_overflow_event, ext_irq_event,
        return_from_irq_instr, core_irq_slot} = ev;
    rwic_top #(.POWERUP_CYCLES(20)) uut (.*);
    rwic_osc_model osc (.*);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (pc_load)
            lv <= pc_load_value;
        npl += int'(pc_load);
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pl(input logic [7:0] m);
        ev <= m;
        @(posedge aclk);
        ev <= 8'h00;
        @(posedge aclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        while (!s_axi_bvalid)
            @(posedge aclk);
        chk(16'(s_axi_bresp), 16'(RESP_OKAY));
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        chk(d[15:0], {8'h00, e});
    endtask
    task automatic wait_run(output int n, input logic s);
        n = 0;
        while ((s ? core_stall : core_reset) !== 1'b0) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic t_por();
        int n;
        wait_run(n, 1'b0);
        chk(16'(n > 4403), 16'h0001);
        chk(16'(n < 4700), 16'h0001);
        rc(CPU_STATUS_OFS, 8'h1C);
    endtask
    task automatic t_irq();
        logic [15:0] vt [5] = '{VEC_EXT_PIN, VEC_TIMER0, VEC_COUNTER_PIN,
            VEC_PERIPH, VEC_PERIPH};
        wr(IRQ_STATUS_OFS, 8'h0F);
        periph_irq_flag <= 1'b1;
        pl(8'h1C);
        rc(IRQ_STATUS_OFS, 8'hFF);
        wr(CPU_STATUS_OFS, 8'h00);
        for (int i = 0; i < 5; i++) begin
            core_pc <= core_pc + 16'h0100;
            pl(8'h01);
            repeat (3) @(posedge aclk);
            chk(lv, vt[i]);
            rc(CPU_STATUS_OFS, 8'h1C);
            pl(8'h02);
        end
        periph_irq_flag <= 1'b0;
        wr(CPU_STATUS_OFS, 8'h10);
        pl(8'h04);
        pl(8'h01);
        repeat (3) @(posedge aclk);
        chk(lv, VEC_PERIPH);
        wr(IRQ_STATUS_OFS, 8'h00);
    endtask
    task automatic t_wdt();
        pl(8'h40);
        repeat (10) @(posedge aclk);
        chk(16'(core_reset), 16'h0000);
        rc(CPU_STATUS_OFS, 8'h14);
        pl(8'h80);
        rc(CPU_STATUS_OFS, 8'h1C);
    endtask
    task automatic t_sleep();
        int n;
        int p;
        wr(IRQ_STATUS_OFS, 8'h01);
        pl(8'h20);
        rc(CPU_STATUS_OFS, 8'h18);
        p = npl;
        pl(8'h04);
        wait_run(n, 1'b1);
        chk(16'(n > 4400), 16'h0001);
        chk(lv, RESET_VECTOR);
        wr(CPU_STATUS_OFS, 8'h00);
        pl(8'h01);
        repeat (3) @(posedge aclk);
        chk(lv, VEC_EXT_PIN);
        chk(16'(npl - p), 16'h0001);
        wr(OSC_CFG_OFS, 8'h02);
        pl(8'h20);
        pl(8'h04);
        wait_run(n, 1'b1);
        chk(16'(n < 10), 16'h0001);
    endtask
    task automatic t_master_clear_pin();
        int n;
        master_clear_pin <= 1'b0;
        repeat (5) @(posedge aclk);
        master_clear_pin <= 1'b1;
        wait_run(n, 1'b0);
        chk(16'(n < 20), 16'h0001);
        rc(CPU_STATUS_OFS, 8'h1C);
        rc(4'hC, 8'h00);
        chk(16'(r), 16'(RESP_SLVERR));
    endtask
    initial begin
        {aresetn, por_trip, periph_irq_flag, ev, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {err_total, num_checks, cyc, npl} = '0;
        master_clear_pin = 1'b1;
        s_axi_wstrb = 4'hF;
        core_pc = 16'h1234;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        por_trip <= 1'b1;
        t_por();
        t_irq();
        t_wdt();
        t_sleep();
        t_master_clear_pin();
        end_sim();
    end
endmodule
